/* File: src/timer16_clock_select.sv */
`timescale 1ns/1ps
module timer16_clock_select (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Source selection
  input wire logic [2:0] clock_source_sel_in,
  input wire logic ext_clock_in,
  // Timer clock enable
  output logic timer_tick_out
);
  import timer16_pkg::*;

  logic [PRESC_W-1:0] presc_r;
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic tick_nxt;

  // Free-running prescaler
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + PRESC_STEP;
    end
  end

  // External pin synchroniser and edge history
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_clock_in;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  always_comb begin
    case (clock_source_sel_in)
      CS_STOP: tick_nxt = 1'b0;
      CS_DIV1: tick_nxt = 1'b1;
      CS_DIV8: tick_nxt = (presc_r & MASK_DIV8) == MASK_DIV8;
      CS_DIV64: tick_nxt = (presc_r & MASK_DIV64) == MASK_DIV64;
      CS_DIV256: tick_nxt = (presc_r & MASK_DIV256) == MASK_DIV256;
      CS_DIV1024: tick_nxt = (presc_r & MASK_DIV1024) == MASK_DIV1024;
      CS_EXT_FALL: tick_nxt = ext_prev_r & ~ext_sync_r;
      CS_EXT_RISE: tick_nxt = ~ext_prev_r & ext_sync_r;
      default: tick_nxt = 1'b0;
    endcase
  end

  // Registered tick
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_tick_out <= 1'b0;
    end else begin
      timer_tick_out <= tick_nxt;
    end
  end
endmodule

/* File: src/timer16_normal_ctc.sv */
`timescale 1ns/1ps
module timer16_normal_ctc #(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [timer16_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Timer inputs
  input wire logic ext_clock_in,
  input wire logic capture_pin_in,
  // Interrupt service acknowledges, one per source
  input wire logic [3:0] service_ack_in,
  // Interrupt source flags
  output logic overflow_flag_out,
  output logic compare_a_flag_out,
  output logic compare_b_flag_out,
  output logic capture_flag_out,
  // Waveform pins
  output logic [PINS-1:0] pin_a_out,
  output logic [PINS-1:0] pin_a_oe_n_out,
  output logic [PINS-1:0] pin_b_out,
  output logic [PINS-1:0] pin_b_oe_n_out
);
  import timer16_pkg::*;

  // Control state
  logic [1:0] act_a_r;
  logic [1:0] act_b_r;
  logic [3:0] waveform_mode_sel_r;
  logic [2:0] clock_source_sel_r;
  logic [PINS-1:0] compare_a_pin_select_r;
  logic [PINS-1:0] compare_b_pin_select_r;
  logic [PINS-1:0] dir_a_r;
  logic [PINS-1:0] dir_b_r;
  // Timer state
  logic [CNT_W-1:0] count_value_r;
  logic [CNT_W-1:0] compare_a_value_r;
  logic [CNT_W-1:0] compare_a_live_r;
  logic [CNT_W-1:0] compare_b_value_r;
  logic [CNT_W-1:0] capture_value_r;
  logic [7:0] temp_high_r;
  logic overflow_flag_r;
  logic compare_a_flag_r;
  logic compare_b_flag_r;
  logic capture_flag_r;
  logic wave_a_r;
  logic wave_b_r;
  logic block_match_r;
  // Bus data phase
  logic dp_write_r;
  logic [ADDR_W-1:0] dp_addr_r;
  // Capture pin synchroniser
  logic cap_meta_r;
  logic cap_sync_r;
  logic cap_prev_r;

  logic timer_tick;
  logic addr_phase;
  logic rd_en;
  logic [7:0] wdata;
  logic [7:0] rd_byte;
  logic [7:0] rd_temp;
  logic rd_latch;
  logic [CNT_W-1:0] top_value;
  logic [CNT_W-1:0] compare_a_eff;
  logic clears_at_top;
  logic buffered_top;
  logic top_match;
  logic cmp_a_hit;
  logic cmp_b_hit;
  logic cap_edge;
  logic set_ovf;
  logic set_cap;
  logic [3:0] flag_clr;

  // Timer clock source
  timer16_clock_select u_clock_select (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clock_source_sel_in(clock_source_sel_r),
    .ext_clock_in(ext_clock_in),
    .timer_tick_out(timer_tick)
  );

  // Bus decode
  assign addr_phase = hsel_in & htrans_in[1] & hready_in;
  assign rd_en = addr_phase & ~hwrite_in;
  assign wdata = hwdata_in[7:0];

  // Address phase capture
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dp_write_r <= 1'b0;
      dp_addr_r <= '0;
    end else begin
      dp_write_r <= addr_phase & hwrite_in;
      if (addr_phase) begin
        dp_addr_r <= haddr_in;
      end
    end
  end

  // Zero-wait OKAY answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // Read mux; low-byte reads fetch high byte into temp
  always_comb begin
    rd_byte = BYTE_RESET;
    rd_temp = BYTE_RESET;
    rd_latch = 1'b0;
    case (haddr_in)
      ADDR_CONTROL_A: rd_byte = {act_a_r, act_b_r, 2'h0,
                                 waveform_mode_sel_r[1:0]};
      ADDR_CONTROL_B: rd_byte = {3'h0, waveform_mode_sel_r[3:2],
                                 clock_source_sel_r};
      ADDR_PIN_SELECT: rd_byte = 8'({compare_b_pin_select_r,
                                     compare_a_pin_select_r});
      ADDR_PIN_DIRECTION: rd_byte = 8'({dir_b_r, dir_a_r});
      ADDR_COUNT_LOW: begin
        rd_byte = count_value_r[7:0];
        rd_temp = count_value_r[15:8];
        rd_latch = 1'b1;
      end
      ADDR_COMPARE_A_LOW: begin
        rd_byte = compare_a_value_r[7:0];
        rd_temp = compare_a_value_r[15:8];
        rd_latch = 1'b1;
      end
      ADDR_COMPARE_B_LOW: begin
        rd_byte = compare_b_value_r[7:0];
        rd_temp = compare_b_value_r[15:8];
        rd_latch = 1'b1;
      end
      ADDR_CAPTURE_LOW: begin
        rd_byte = capture_value_r[7:0];
        rd_temp = capture_value_r[15:8];
        rd_latch = 1'b1;
      end
      ADDR_COUNT_HIGH, ADDR_COMPARE_A_HIGH,
      ADDR_COMPARE_B_HIGH, ADDR_CAPTURE_HIGH: rd_byte = temp_high_r;
      ADDR_FLAGS: rd_byte = {4'h0, capture_flag_r, compare_b_flag_r,
                             compare_a_flag_r, overflow_flag_r};
      default: rd_byte = BYTE_RESET;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= '0;
    end else if (rd_en) begin
      hrdata_out <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_high_r <= BYTE_RESET;
    end else if (dp_write_r && (dp_addr_r == ADDR_COUNT_HIGH ||
                 dp_addr_r == ADDR_COMPARE_A_HIGH ||
                 dp_addr_r == ADDR_COMPARE_B_HIGH ||
                 dp_addr_r == ADDR_CAPTURE_HIGH)) begin
      // high byte goes to temp only
      temp_high_r <= wdata;
    end else if (rd_en && rd_latch) begin
      temp_high_r <= rd_temp;
    end
  end

  // Control registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_a_r <= ACT_NONE;
      act_b_r <= ACT_NONE;
      waveform_mode_sel_r <= MODE_NORMAL;
      clock_source_sel_r <= CS_STOP;
      compare_a_pin_select_r <= '0;
      compare_b_pin_select_r <= '0;
      dir_a_r <= '0;
      dir_b_r <= '0;
    end else if (dp_write_r) begin
      case (dp_addr_r)
        ADDR_CONTROL_A: begin
          act_a_r <= wdata[CTRL_A_ACT_A_LSB +: 2];
          act_b_r <= wdata[CTRL_A_ACT_B_LSB +: 2];
          waveform_mode_sel_r[1:0] <= wdata[CTRL_A_MODE_LSB +: 2];
        end
        ADDR_CONTROL_B: begin
          waveform_mode_sel_r[3:2] <= wdata[CTRL_B_MODE_LSB +: 2];
          clock_source_sel_r <= wdata[CTRL_B_CS_LSB +: 3];
        end
        ADDR_PIN_SELECT: begin
          compare_a_pin_select_r <= wdata[PINS-1:0];
          compare_b_pin_select_r <= wdata[PIN_B_LSB +: PINS];
        end
        ADDR_PIN_DIRECTION: begin
          dir_a_r <= wdata[PINS-1:0];
          dir_b_r <= wdata[PIN_B_LSB +: PINS];
        end
        default: begin
        end
      endcase
    end
  end

  // Top selection per mode
  always_comb begin
    clears_at_top = 1'b1;
    buffered_top = 1'b0;
    top_value = COUNT_MAX;
    case (waveform_mode_sel_r)
      // top from compare A or capture
      MODE_CTC_COMPARE_A: top_value = compare_a_value_r;
      MODE_CTC_CAPTURE: top_value = capture_value_r;
      MODE_TOP_BUFFERED: begin
        top_value = compare_a_live_r;
        buffered_top = 1'b1;
      end
      default: clears_at_top = 1'b0;
    endcase
  end

  // unbuffered compare A outside mode 15
  assign compare_a_eff = buffered_top ? compare_a_live_r : compare_a_value_r;

  // equality only, a passed top waits for wrap
  assign top_match = timer_tick & clears_at_top & ~block_match_r &
                     (count_value_r == top_value);
  assign cmp_a_hit = timer_tick & ~block_match_r &
                     (count_value_r == compare_a_eff);
  assign cmp_b_hit = timer_tick & ~block_match_r &
                     (count_value_r == compare_b_value_r);

  // Counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_value_r <= COUNT_RESET;
    end else if (dp_write_r && dp_addr_r == ADDR_COUNT_LOW) begin
      // write wins at any time, all sixteen bits
      count_value_r <= {temp_high_r, wdata};
    end else if (top_match) begin
      count_value_r <= COUNT_BOTTOM;
    end else if (timer_tick) begin
      count_value_r <= count_value_r + COUNT_STEP;
    end
  end

  // Count write masks the match on the next tick
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      block_match_r <= 1'b0;
    end else if (dp_write_r && dp_addr_r == ADDR_COUNT_LOW) begin
      block_match_r <= 1'b1;
    end else if (timer_tick) begin
      block_match_r <= 1'b0;
    end
  end

  // Compare registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_a_value_r <= COUNT_RESET;
      compare_b_value_r <= COUNT_RESET;
    end else if (dp_write_r) begin
      if (dp_addr_r == ADDR_COMPARE_A_LOW) begin
        compare_a_value_r <= {temp_high_r, wdata};
      end
      if (dp_addr_r == ADDR_COMPARE_B_LOW) begin
        compare_b_value_r <= {temp_high_r, wdata};
      end
    end
  end

  // live compare A reloads at top in mode 15
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_a_live_r <= COUNT_RESET;
    end else if (!buffered_top || top_match) begin
      compare_a_live_r <= compare_a_value_r;
    end
  end

  // Capture pin synchroniser
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_meta_r <= 1'b0;
      cap_sync_r <= 1'b0;
      cap_prev_r <= 1'b0;
    end else begin
      cap_meta_r <= capture_pin_in;
      cap_sync_r <= cap_meta_r;
      cap_prev_r <= cap_sync_r;
    end
  end

  // Capture on rising edge unless capture is the top
  assign cap_edge = cap_sync_r & ~cap_prev_r &
                    (waveform_mode_sel_r != MODE_CTC_CAPTURE);

  // Capture register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_value_r <= COUNT_RESET;
    end else if (dp_write_r && dp_addr_r == ADDR_CAPTURE_LOW) begin
      // capture top takes effect at once
      capture_value_r <= {temp_high_r, wdata};
    end else if (cap_edge) begin
      capture_value_r <= count_value_r;
    end
  end

  // overflow when the count wraps from max, or at top in mode 15
  assign set_ovf = timer_tick & ~(dp_write_r &&
                   dp_addr_r == ADDR_COUNT_LOW) &
                   ((count_value_r == COUNT_MAX && !top_match) ||
                    (top_match && (buffered_top ||
                     count_value_r == COUNT_MAX)));
  // capture flag at top when capture defines it
  assign set_cap = cap_edge |
                   (top_match &
                    (waveform_mode_sel_r == MODE_CTC_CAPTURE));

  // Flag clears by write-one or by interrupt service
  assign flag_clr = service_ack_in |
                    ((dp_write_r && dp_addr_r == ADDR_FLAGS) ?
                     wdata[3:0] : 4'h0);

  // four sticky sources, set beats clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overflow_flag_r <= 1'b0;
      compare_a_flag_r <= 1'b0;
      compare_b_flag_r <= 1'b0;
      capture_flag_r <= 1'b0;
    end else begin
      overflow_flag_r <= set_ovf |
                         (overflow_flag_r & ~flag_clr[FLAG_OVERFLOW]);
      // compare A flag at every compare A match, top or not
      compare_a_flag_r <= cmp_a_hit |
                          (compare_a_flag_r & ~flag_clr[FLAG_COMPARE_A]);
      compare_b_flag_r <= cmp_b_hit |
                          (compare_b_flag_r & ~flag_clr[FLAG_COMPARE_B]);
      capture_flag_r <= set_cap |
                        (capture_flag_r & ~flag_clr[FLAG_CAPTURE]);
    end
  end

  assign overflow_flag_out = overflow_flag_r;
  assign compare_a_flag_out = compare_a_flag_r;
  assign compare_b_flag_out = compare_b_flag_r;
  assign capture_flag_out = capture_flag_r;

  // Compare output action on a match
  function automatic logic wave_next(input logic cur, input logic [1:0] act);
    case (act)
      ACT_TOGGLE: wave_next = ~cur;
      ACT_CLEAR: wave_next = 1'b0;
      ACT_SET: wave_next = 1'b1;
      default: wave_next = cur;
    endcase
  endfunction

  // act on each compare match; wave A toggles every 1 + compare A ticks in mode 4
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      if (cmp_a_hit) begin
        wave_a_r <= wave_next(wave_a_r, act_a_r);
      end
      if (cmp_b_hit) begin
        wave_b_r <= wave_next(wave_b_r, act_b_r);
      end
    end
  end

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pin_a_out[i] <= 1'b0;
        pin_a_oe_n_out[i] <= 1'b1;
        pin_b_out[i] <= 1'b0;
        pin_b_oe_n_out[i] <= 1'b1;
      end else begin
        pin_a_out[i] <= wave_a_r;
        pin_b_out[i] <= wave_b_r;
        // driven only with direction and select set
        pin_a_oe_n_out[i] <= ~(dir_a_r[i] & compare_a_pin_select_r[i] &
                               (act_a_r != ACT_NONE));
        pin_b_oe_n_out[i] <= ~(dir_b_r[i] & compare_b_pin_select_r[i] &
                               (act_b_r != ACT_NONE));
      end
    end
  end
endmodule

/* File: src/timer16_pkg.sv */
package timer16_pkg;
  // Bus and data widths
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 10;

  // Register byte addresses, one word each
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PIN_SELECT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_A_LOW = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_A_HIGH = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_B_LOW = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_COMPARE_B_HIGH = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_LOW = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_HIGH = 8'h2C;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h30;

  // Field positions
  localparam int CTRL_A_ACT_A_LSB = 6;
  localparam int CTRL_A_ACT_B_LSB = 4;
  localparam int CTRL_A_MODE_LSB = 0;
  localparam int CTRL_B_MODE_LSB = 3;
  localparam int CTRL_B_CS_LSB = 0;
  localparam int PIN_B_LSB = 4;
  localparam int FLAG_OVERFLOW = 0;
  localparam int FLAG_COMPARE_A = 1;
  localparam int FLAG_COMPARE_B = 2;
  localparam int FLAG_CAPTURE = 3;

  // Reset values and count limits
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] COUNT_STEP = 16'h0001;

  // Waveform modes
  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h0,
    MODE_CTC_COMPARE_A = 4'h4,
    MODE_CTC_CAPTURE = 4'hC,
    MODE_TOP_BUFFERED = 4'hF
  } wave_mode_t;

  // Compare output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Clock source codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler masks, tick when masked count is all ones
  localparam logic [PRESC_W-1:0] MASK_DIV8 = 10'h007;
  localparam logic [PRESC_W-1:0] MASK_DIV64 = 10'h03F;
  localparam logic [PRESC_W-1:0] MASK_DIV256 = 10'h0FF;
  localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3FF;
  localparam logic [PRESC_W-1:0] PRESC_STEP = 10'h001;
endpackage

/* File: tb/tb_timer16_normal_ctc.sv */
`timescale 1ns/1ps
module tb_timer16_normal_ctc;
  import timer16_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel_in = 1'b0;
  logic ext_clk = 1'b0;
  logic [ADDR_W-1:0] haddr_in = 8'h00;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out, rd;
  logic hreadyout_out, hresp_out, ovf, cmpa, cmpb, capf, p;
  logic [3:0] service_ack_in = 4'h0;
  logic [3:0] pa, pa_oe_n, pb, pb_oe_n;
  logic [15:0] v;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  // Register rows: address, write data, read back
  logic [7:0] t_a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h30, 8'h40};
  logic [7:0] t_w [6] = '{8'hF0, 8'h18, 8'hA5, 8'h5A, 8'h00, 8'hFF};
  logic [7:0] t_e [6] = '{8'hF0, 8'h18, 8'hA5, 8'h5A, 8'h00, 8'h00};
  // Clear-on-compare rows: control B, cycles between toggles
  logic [7:0] m_b [3] = '{8'h09, 8'h19, 8'h0A};
  int m_per [3] = '{4, 6, 32};

  always #20 clk_in = ~clk_in;

  timer16_normal_ctc timer16_normal_ctc_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .ext_clock_in(ext_clk), .capture_pin_in(1'b0),
    .service_ack_in(service_ack_in), .overflow_flag_out(ovf),
    .compare_a_flag_out(cmpa), .compare_b_flag_out(cmpb),
    .capture_flag_out(capf), .pin_a_out(pa), .pin_a_oe_n_out(pa_oe_n),
    .pin_b_out(pb), .pin_b_oe_n_out(pb_oe_n));

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB transfer, read data left in rd
  task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    hwrite_in <= wr;
    htrans_in <= 2'h2;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask

  task automatic w16(logic [7:0] a, logic [15:0] d);
    bus(1'b1, a + 8'h04, d[15:8]);
    bus(1'b1, a, d[7:0]);
  endtask

  task automatic r16(logic [7:0] a);
    bus(1'b0, a, 8'h00);
    v[7:0] = rd[7:0];
    bus(1'b0, a + 8'h04, 8'h00);
    v[15:8] = rd[7:0];
  endtask

  task automatic wait_for(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 60) begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // Rising edges on the external clock pin, six cycles apart
  task automatic ext_pulses(int k);
    repeat (k) begin
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk_in);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask

  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_in);
    check("ready in reset", 32'h0, {31'h0, hreadyout_out});
    check("pin A drive in reset", 32'hF, {28'h0, pa_oe_n});
    rst_n_in <= 1'b1;
    bus(1'b0, 8'h00, 8'h00);
    check("control A reset", 32'h0, rd);
    foreach (t_a[i]) begin
      bus(1'b1, t_a[i], t_w[i]);
      bus(1'b0, t_a[i], 8'h00);
      check("register", {24'h0, t_e[i]}, rd);
    end
    $display("register table done");
    // one high byte shared by two writes
    bus(1'b1, 8'h14, 8'h12);
    bus(1'b1, 8'h18, 8'h34);
    bus(1'b1, 8'h10, 8'h56);
    r16(8'h18);
    check("compare A", 32'h1234, {16'h0, v});
    r16(8'h10);
    check("count", 32'h1256, {16'h0, v});
    $display("shared high byte done");
    // normal mode wraps past compare A
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h04, 8'h00);
    w16(8'h18, 16'hFFF8);
    w16(8'h10, 16'hFFF0);
    r16(8'h10);
    check("count write", 32'hFFF0, {16'h0, v});
    bus(1'b1, 8'h04, 8'h01);
    wait_for(ovf);
    check("overflow", 32'h1, {31'h0, ovf});
    bus(1'b1, 8'h04, 8'h00);
    r16(8'h10);
    check("wrapped", 32'h1, {31'h0, v < 16'h0040});
    check("overflow held", 32'h1, {31'h0, ovf});
    service_ack_in <= 4'h1;
    @(posedge clk_in);
    service_ack_in <= 4'h0;
    repeat (2) @(posedge clk_in);
    check("overflow serviced", 32'h0, {31'h0, ovf});
    $display("normal mode done");
    // toggle on compare A match, compare A or capture as top
    w16(8'h18, 16'h0003);
    w16(8'h28, 16'h0005);
    bus(1'b1, 8'h08, 8'h01);
    bus(1'b1, 8'h0C, 8'h01);
    bus(1'b1, 8'h00, 8'h40);
    foreach (m_b[i]) begin
      bus(1'b1, 8'h04, 8'h00);
      w16(8'h10, 16'h0000);
      bus(1'b1, 8'h30, 8'h0F);
      bus(1'b1, 8'h04, m_b[i]);
      if (i != 1) wait_for(cmpa);
      else wait_for(capf);
      check("top flag", 32'h1, {31'h0, (i == 1) ? capf : cmpa});
      p = pa[0];
      wait_for(p);
      for (int k = 0; k < 2; k++) begin
        p = pa[0];
        n = 0;
        while (pa[0] === p && n < 40) begin
          @(posedge clk_in);
          n++;
        end
      end
      check("toggle spacing", m_per[i], n);
      check("no overflow", 32'h0, {31'h0, ovf});
      check("pin drives", 32'hE, {28'h0, pa_oe_n});
      check("B pins off", 32'hF, {28'h0, pb_oe_n});
    end
    $display("clear on compare done");
    // external rising edges, compare B set then clear
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h00, 8'h70);
    w16(8'h20, 16'h0002);
    bus(1'b1, 8'h08, 8'h11);
    bus(1'b1, 8'h0C, 8'h11);
    w16(8'h10, 16'h0000);
    bus(1'b1, 8'h30, 8'h0F);
    bus(1'b1, 8'h04, 8'h0F);
    ext_pulses(3);
    check("compare B flag", 32'h1, {31'h0, cmpb});
    check("B set", 32'hF, {28'h0, pb});
    check("B pin drives", 32'hE, {28'h0, pb_oe_n});
    r16(8'h10);
    check("external count", 32'h3, {16'h0, v});
    bus(1'b1, 8'h00, 8'h60);
    ext_pulses(4);
    check("B clear", 32'h0, {28'h0, pb});
    $display("external clock done");
    // top below the count waits for the wrap
    bus(1'b1, 8'h04, 8'h08);
    w16(8'h10, 16'hFFF0);
    bus(1'b1, 8'h30, 8'h0F);
    bus(1'b1, 8'h04, 8'h09);
    wait_for(ovf);
    check("wrap before match", 32'h1, {31'h0, ovf});
    check("match missed", 32'h0, {31'h0, cmpa});
    repeat (5) @(posedge clk_in);
    check("match after wrap", 32'h1, {31'h0, cmpa});
    $display("missed top done");
    // Reset in mid-run clears flags and releases pins
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("flags in reset", 32'h0, {28'h0, ovf, cmpa, cmpb, capf});
    check("pins in reset", 32'hFF, {24'h0, pa_oe_n, pb_oe_n});
    rst_n_in <= 1'b1;
    bus(1'b0, 8'h04, 8'h00);
    check("control B reset", 32'h0, rd);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule

/* File: tb/timer16_normal_ctc_properties.sv */
`timescale 1ns/1ps
module timer16_normal_ctc_properties #(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Flags and pins
  input wire logic [3:0] service_ack_in,
  input wire logic overflow_flag_out,
  input wire logic compare_a_flag_out,
  input wire logic compare_b_flag_out,
  input wire logic capture_flag_out,
  input wire logic [PINS-1:0] pin_a_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Bus answers
  a_ready_up: assert property (
    $past(rst_n_in) |-> hreadyout_out) else $error("ready low");
  a_resp_okay: assert property (
    hresp_out == 1'b0) else $error("response not okay");
  a_rdata_upper: assert property (
    hrdata_out[31:8] == 24'h0) else $error("read data upper bits set");
  a_rdata_hold: assert property (
    !$past(hsel_in && htrans_in[1] && !hwrite_in) |-> $stable(hrdata_out))
    else $error("read data moved without a read");
  // Flags only fall on a clear
  a_ovf_sticky: assert property (
    overflow_flag_out && !service_ack_in[0] && !$past(hsel_in)
    |=> overflow_flag_out) else $error("overflow flag dropped");
  a_cmpa_sticky: assert property (
    compare_a_flag_out && !service_ack_in[1] && !$past(hsel_in)
    |=> compare_a_flag_out) else $error("compare A flag dropped");
  a_cmpb_sticky: assert property (
    compare_b_flag_out && !service_ack_in[2] && !$past(hsel_in)
    |=> compare_b_flag_out) else $error("compare B flag dropped");
  a_cap_sticky: assert property (
    capture_flag_out && !service_ack_in[3] && !$past(hsel_in)
    |=> capture_flag_out) else $error("capture flag dropped");
  // Main scenarios
  c_ovf: cover property ($rose(overflow_flag_out));
  c_cmpa: cover property ($rose(compare_a_flag_out));
  c_cmpb: cover property ($rose(compare_b_flag_out));
  c_toggle: cover property ($changed(pin_a_out));
endmodule

bind timer16_normal_ctc timer16_normal_ctc_properties #(.PINS(PINS))
  timer16_normal_ctc_properties_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .service_ack_in(service_ack_in),
  .overflow_flag_out(overflow_flag_out),
  .compare_a_flag_out(compare_a_flag_out),
  .compare_b_flag_out(compare_b_flag_out),
  .capture_flag_out(capture_flag_out), .pin_a_out(pin_a_out));
